// >>> sim/dso_top_bench.sv
// Purpose: Self-checking bench for the status output selector
// Assumes: Timer tick shortened to 4 clocks
// Notes: Random level stimulus from a fixed seed, then fixed corner tables
`include "dso_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module dso_top_bench;
  import dso_pkg::*;
  // ****************************************
  // Signals and helpers
  // ****************************************
  localparam logic [15:0] RC = 16'h0104;
  localparam logic [15:0] MF = 16'h0258;
  logic i_sys_clk = 0, i_rst_n = 0, i_avs_read = 0, i_avs_write = 0, i_running = 0, i_ramping = 0;
  logic i_fault_event = 0, i_fault_clear = 0, i_comm_activity = 0, i_option_activity = 0;
  logic [3:0] i_avs_address = 0, i_avs_byteenable = 4'hf;
  logic [31:0] i_avs_writedata = 0, o_avs_readdata, q;
  logic [15:0] i_out_freq = 0, i_target_freq = 0, i_out_current = 0, i_pid_err_mag = 0;
  logic [15:0] i_pid_feedback = 0, i_volt_ain = 16'h0300, i_cur_ain = 16'h0300, o_meter_value, o_meter_full;
  logic o_avs_waitrequest, o_out11, o_relay;
  logic [5:0] c, fr, lc [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06};
  integer seed, n_fail = 0, comparisons = 0;
  dso_top #(.TICK_CYCLES(4), .RATED_CUR(RC), .MAX_FREQ(MF)) DUT (.i_sys_clk, .i_rst_n, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_running, .i_ramping, .i_out_freq, .i_target_freq, .i_out_current, .i_pid_err_mag, .i_pid_feedback,
    .i_volt_ain, .i_cur_ain, .i_fault_event, .i_fault_clear, .i_comm_activity, .i_option_activity,
    .o_out11, .o_relay, .o_meter_value, .o_meter_full);
  // Clock at 20 MHz and overall limit
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Settle on falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // One Avalon transfer held until waitrequest is low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    i_avs_write <= w;
    i_avs_read <= !w;
    // Sample waitrequest and read data at rising edges only
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_fail++;
      give_verdict();
    end
    q = o_avs_readdata;
    i_avs_write <= 0;
    i_avs_read <= 0;
  endtask
  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(q, e)
  endtask
  function automatic logic [31:0] cfgw(input logic [5:0] f, input logic p, input logic [5:0] r, input logic pr,
                                       input logic m, input logic [1:0] u);
    return {6'h0, u, 7'h0, m, 1'b0, pr, r, 1'b0, p, f};
  endfunction
  function automatic logic [31:0] rstv(input int i);
    case (i)
      0: return `DSO_CFG_RST;
      1, 2: return {16'h0, RC};
      3: return `DSO_PID_DEV_RST;
      4: return `DSO_PID_LIM_RST;
      default: return `DSO_ZERO_RST;
    endcase
  endfunction
  // Level function expected from current inputs
  function automatic logic expf(input logic [5:0] f);
    case (f)
      6'h00: return i_running;
      6'h01: return i_running && !i_ramping && i_out_freq == i_target_freq;
      6'h02: return i_running && i_out_freq >= i_target_freq;
      6'h03: return i_out_current > 16'h0100;
      6'h04: return i_pid_err_mag > 16'h001e;
      6'h06: return i_volt_ain < 16'h0200 || i_cur_ain < `DSO_AIN_4MA;
      default: return 1'b0;
    endcase
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 279;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1;
    cyc(3);
    `CHK(o_out11, 1'b0)
    `CHK(o_relay, 1'b1)
    for (int i = 0; i < 16; i++) if (i != 9) rdchk(i[3:0], rstv(i));
    wrt(1, 32'hffff);
    rdchk(1, {16'h0, RC[14:0], 1'b0});
    wrt(3, 0);
    bus(1'b1, 4'h3, 32'hffffffff, 4'h1);
    rdchk(3, 32'hff);
    wrt(10, 32'h1234);
    rdchk(10, 0);
    wrt(2, 32'h100);
    wrt(3, 32'h1e);
    wrt(5, 32'h200);
    // Random levels, outputs on independent codes
    for (int k = 0; k < 60; k++) begin
      c = lc[k % 6];
      fr = lc[(k + 2) % 6];
      wrt(0, cfgw(c, k[0], fr, 1'b0, 1'b0, 2'h0));
      i_running <= $random(seed);
      i_ramping <= $random(seed);
      i_out_freq <= $random(seed) & 3;
      i_target_freq <= $random(seed) & 3;
      i_out_current <= $random(seed) & 16'h01ff;
      i_pid_err_mag <= $random(seed) & 16'h003f;
      i_volt_ain <= $random(seed) & 16'h03ff;
      i_cur_ain <= $random(seed) & 16'h03ff;
      cyc(3);
      `CHK(o_out11, expf(c) ^ k[0])
      `CHK(o_relay, expf(fr))
    end
    // Fault latch, event wins over clear
    wrt(0, cfgw(6'h3f, 1'b0, 6'h05, 1'b0, 1'b0, 2'h0));
    for (int s = 0; s < 3; s++) begin
      @(posedge i_sys_clk);
      i_fault_event <= s < 2;
      i_fault_clear <= s > 0;
      @(posedge i_sys_clk);
      i_fault_event <= 0;
      i_fault_clear <= 0;
      cyc(6);
      `CHK(o_relay, s < 2)
    end
    // Second stage hysteresis
    wrt(4, {16'h0300, 16'h0100});
    wrt(0, cfgw(6'h07, 1'b0, 6'h05, 1'b1, 1'b0, 2'h0));
    for (int s = 0; s < 7; s++) begin
      @(posedge i_sys_clk);
      i_running <= s != 5 && s != 6;
      i_pid_feedback <= s == 2 ? 16'h0400 : (s == 1 || s == 3) ? 16'h0200 : 16'h0050;
      cyc(4);
      `CHK(o_out11, s < 2 || s == 4)
    end
    // Watchdog and option link timeouts
    wrt(6, 3);
    wrt(7, 3);
    wrt(0, cfgw(6'h08, 1'b0, 6'h0a, 1'b0, 1'b0, 2'h0));
    for (int s = 0; s < 8; s++) begin
      @(posedge i_sys_clk);
      i_comm_activity <= 1;
      i_option_activity <= 1;
      @(posedge i_sys_clk);
      i_comm_activity <= 0;
      i_option_activity <= 0;
      cyc(3);
      `CHK(o_out11, 1'b0)
      `CHK(o_relay, 1'b0)
    end
    cyc(40);
    `CHK(o_out11, 1'b1)
    `CHK(o_relay, 1'b1)
    // Gate of run and current over
    for (int s = 0; s < 16; s++) begin
      wrt(8, {10'h0, 6'h03, 2'h0, 6'h00, 6'h0, s[3:2]});
      wrt(0, cfgw(6'h09, 1'b0, 6'h05, 1'b1, 1'b0, 2'h0));
      i_running <= s[0];
      i_out_current <= s[1] ? 16'h0200 : 16'h0010;
      cyc(4);
      `CHK(o_out11, s[3:2] == 0 ? s[0] & s[1] : s[3:2] == 1 ? s[0] | s[1] : s[3:2] == 2 ? s[0] ^ s[1] : 1'b0)
    end
    // Underload modes, warning only
    wrt(1, 32'h80);
    for (int s = 0; s < 7; s++) begin
      wrt(0, cfgw(6'h2b, 1'b0, 6'h05, 1'b1, 1'b0, s == 3 ? 2'h0 : s == 6 ? 2'h3 : s > 3 ? 2'h2 : 2'h1));
      i_running <= 1;
      i_ramping <= s == 1 || s == 4;
      i_out_current <= s == 2 ? 16'h0090 : 16'h0010;
      cyc(5);
      `CHK(o_out11, s < 2 || s == 5)
      `CHK(o_relay, 1'b1)
    end
    // Meter source and scale
    wrt(0, cfgw(6'h00, 1'b0, 6'h05, 1'b1, 1'b1, 2'h1));
    cyc(3);
    `CHK(o_meter_value, i_out_current)
    `CHK(o_meter_full, {RC[14:0], 1'b0})
    // Reset in mid-run
    @(posedge i_sys_clk);
    i_rst_n <= 0;
    cyc(2);
    `CHK(o_relay, 1'b0)
    @(posedge i_sys_clk);
    i_rst_n <= 1;
    cyc(3);
    rdchk(0, `DSO_CFG_RST);
    `CHK(o_meter_full, MF)
    give_verdict();
  end
endmodule
bind dso_top dso_top_props #(.TICK_CYCLES(TICK_CYCLES), .RATED_CUR(RATED_CUR), .MAX_FREQ(MAX_FREQ)) u_props (
  .i_sys_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_readdata, .o_avs_waitrequest, .i_running, .i_ramping, .i_out_freq, .i_target_freq, .i_out_current,
  .i_pid_err_mag, .i_pid_feedback, .i_volt_ain, .i_cur_ain, .i_fault_event, .i_fault_clear, .i_comm_activity,
  .i_option_activity, .o_out11, .o_relay, .o_meter_value, .o_meter_full);
`default_nettype wire

// >>> sim/dso_top_props.sv
// Purpose: Port-level checks for the status output selector
// Assumes: CFG is only changed through Avalon writes seen here, full or byte-lane partial
// Notes: A shadow of CFG follows the bus so checks know the selection
`include "dso_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dso_top_props
  import dso_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter logic [15:0] RATED_CUR = 16'h0104,
  parameter logic [15:0] MAX_FREQ = 16'h0258
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Drive state
  input wire logic i_running,
  input wire logic i_ramping,
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_target_freq,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_pid_err_mag,
  input wire logic [15:0] i_pid_feedback,
  input wire logic [15:0] i_volt_ain,
  input wire logic [15:0] i_cur_ain,
  // Events
  input wire logic i_fault_event,
  input wire logic i_fault_clear,
  input wire logic i_comm_activity,
  input wire logic i_option_activity,
  // Outputs
  input wire logic o_out11,
  input wire logic o_relay,
  input wire logic [15:0] o_meter_value,
  input wire logic [15:0] o_meter_full
);
  // ****************************************
  // Shadow of the selection register
  // ****************************************
  logic [31:0] cfg;
  wire take_cfg = i_avs_write && !o_avs_waitrequest && (i_avs_address == `DSO_REG_CFG);
  wire [31:0] next_cfg = {i_avs_byteenable[3] ? i_avs_writedata[31:24] : cfg[31:24],
    i_avs_byteenable[2] ? i_avs_writedata[23:16] : cfg[23:16],
    i_avs_byteenable[1] ? i_avs_writedata[15:8] : cfg[15:8],
    i_avs_byteenable[0] ? i_avs_writedata[7:0] : cfg[7:0]};
  wire reached = i_running && !i_ramping && (i_out_freq == i_target_freq);
  wire over = i_running && (i_out_freq >= i_target_freq);
  wire pol11 = cfg[6];
  wire polry = cfg[14];
  wire msel = cfg[16];
  // Lane-merged capture of CFG writes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= `DSO_CFG_RST;
    end else if (take_cfg) begin
      cfg <= next_cfg;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RST_OUT: assert property ($rose(i_rst_n) |-> !o_out11 && !o_relay && o_avs_waitrequest)
    else $error("outputs not idle out of reset");
  AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  AST_WAIT_ANSWER: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest)
    else $error("bus answer late");
  AST_RUN: assert property (cfg[5:0] == 6'h00 |=> o_out11 == ($past(i_running) ^ $past(pol11)))
    else $error("run output wrong");
  AST_REACHED: assert property (cfg[5:0] == 6'h01 |=> o_out11 == ($past(reached) ^ $past(pol11)))
    else $error("speed reached output wrong");
  AST_OVER: assert property (cfg[13:8] == 6'h02 |=> o_relay == ($past(over) ^ $past(polry)))
    else $error("speed over output wrong");
  AST_FAULT: assert property (i_fault_event && cfg[13:8] == 6'h05 && !polry |-> ##2 o_relay)
    else $error("fault not latched");
  AST_POL: assert property (cfg[5:0] == 6'h3f |=> o_out11 == $past(pol11))
    else $error("polarity of idle code wrong");
  AST_METER_FULL: assert property (1'b1 |=> o_meter_full == ($past(msel) ? {RATED_CUR[14:0], 1'b0} : MAX_FREQ))
    else $error("meter scale wrong");
  AST_METER_VAL: assert property (1'b1 |=> o_meter_value == ($past(msel) ? $past(i_out_current) : $past(i_out_freq)))
    else $error("meter source wrong");
endmodule
`default_nettype wire

// >>> verilog/dso_consts.svh
// Purpose: Named offsets, fields, reset values and timing for the status output selector
// Assumes: Register index is the Avalon word address; byte address is four times it
// Notes: Definitions only
`ifndef DSO_CONSTS_SVH
`define DSO_CONSTS_SVH

// ****************************************
// Register word indices
// ****************************************
`define DSO_REG_CFG 4'h0
`define DSO_REG_UL_LEVEL 4'h1
`define DSO_REG_OL_LEVEL 4'h2
`define DSO_REG_PID_DEV 4'h3
`define DSO_REG_PID_LIM 4'h4
`define DSO_REG_LOSS 4'h5
`define DSO_REG_WDOG 4'h6
`define DSO_REG_OPT_TO 4'h7
`define DSO_REG_GATE 4'h8
`define DSO_REG_STATUS 4'h9
`define DSO_NUM_RW 9

// ****************************************
// Field positions
// ****************************************
`define DSO_CFG_F11 5:0
`define DSO_CFG_P11 6
`define DSO_CFG_FRY 13:8
`define DSO_CFG_PRY 14
`define DSO_CFG_METER 16
`define DSO_CFG_ULMODE 25:24
`define DSO_LVL 15:0
`define DSO_LIM_LOWER 15:0
`define DSO_LIM_UPPER 31:16
`define DSO_GATE_OP 1:0
`define DSO_GATE_A 13:8
`define DSO_GATE_B 21:16
`define DSO_ST_FLAGS 11:0
`define DSO_ST_OUT11 16
`define DSO_ST_RELAY 17

// ****************************************
// Reset values
// ****************************************
`define DSO_CFG_RST 32'h0100_4501
`define DSO_PID_LIM_RST 32'h03e8_0000
`define DSO_PID_DEV_RST 32'h0000_001e
`define DSO_ZERO_RST 32'h0000_0000

// ****************************************
// Levels and timing
// ****************************************
`define DSO_AIN_4MA 16'h0190
`define DSO_TICK_NS 1000000
`define DSO_CLK_NS 50
`define DSO_CNT_MAX 16'hffff

`endif

// >>> verilog/dso_func_mux.sv
// Purpose: Picks one status flag by function code
// Assumes: Flag bit n belongs to the n-th code of dso_func_t
// Notes: Unknown codes give a low result
`timescale 1ns/1ns
`default_nettype none
module dso_func_mux
  import dso_pkg::*;
(
  // Selection
  input wire logic [5:0] i_code,
  input wire logic [11:0] i_flags,
  // Result
  output logic o_hit
);

  // ****************************************
  // Code decode
  // ****************************************
  // Map code to flag position
  always_comb begin
    case (dso_func_t'(i_code))
      DSO_F_RUN: o_hit = i_flags[0];
      DSO_F_SPD_REACHED: o_hit = i_flags[1];
      DSO_F_SPD_OVER: o_hit = i_flags[2];
      DSO_F_CUR_OVER: o_hit = i_flags[3];
      DSO_F_PID_ERR: o_hit = i_flags[4];
      DSO_F_FAULT: o_hit = i_flags[5];
      DSO_F_INPUT_LOSS: o_hit = i_flags[6];
      DSO_F_PID_STAGE2: o_hit = i_flags[7];
      DSO_F_WDOG: o_hit = i_flags[8];
      DSO_F_GATE: o_hit = i_flags[9];
      DSO_F_OPT_LINK: o_hit = i_flags[10];
      DSO_F_UNDERLOAD: o_hit = i_flags[11];
      default: o_hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// >>> verilog/dso_pkg.sv
// Purpose: Types shared by the status output selector files
// Assumes: Function codes are six bits wide
// Notes: Flag vector index order follows dso_func_t
package dso_pkg;

  // Output function codes
  typedef enum logic [5:0] {
    DSO_F_RUN = 6'h00,
    DSO_F_SPD_REACHED = 6'h01,
    DSO_F_SPD_OVER = 6'h02,
    DSO_F_CUR_OVER = 6'h03,
    DSO_F_PID_ERR = 6'h04,
    DSO_F_FAULT = 6'h05,
    DSO_F_INPUT_LOSS = 6'h06,
    DSO_F_PID_STAGE2 = 6'h07,
    DSO_F_WDOG = 6'h08,
    DSO_F_GATE = 6'h09,
    DSO_F_OPT_LINK = 6'h0a,
    DSO_F_UNDERLOAD = 6'h2b
  } dso_func_t;

  // Underload detector modes
  typedef enum logic [1:0] {
    DSO_UL_OFF = 2'h0,
    DSO_UL_ALL = 2'h1,
    DSO_UL_CONST = 2'h2
  } dso_ul_mode_t;

  // Gate operations
  typedef enum logic [1:0] {
    DSO_G_AND = 2'h0,
    DSO_G_OR = 2'h1,
    DSO_G_XOR = 2'h2
  } dso_gate_op_t;

endpackage

// >>> verilog/dso_top.sv
// Purpose: Drive status output selector with Avalon-MM register access
// Assumes: Status inputs come from logic on i_sys_clk
// Notes: One wait state on every bus access
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`include "dso_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module dso_top
  import dso_pkg::*;
#(
  parameter int TICK_CYCLES = `DSO_TICK_NS / `DSO_CLK_NS,
  parameter logic [15:0] RATED_CUR = 16'h0104,
  parameter logic [15:0] MAX_FREQ = 16'h0258
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Drive state
  input wire logic i_running,
  input wire logic i_ramping,
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_target_freq,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_pid_err_mag,
  input wire logic [15:0] i_pid_feedback,
  input wire logic [15:0] i_volt_ain,
  input wire logic [15:0] i_cur_ain,
  // Events
  input wire logic i_fault_event,
  input wire logic i_fault_clear,
  input wire logic i_comm_activity,
  input wire logic i_option_activity,
  // Outputs
  output logic o_out11,
  output logic o_relay,
  output logic [15:0] o_meter_value,
  output logic [15:0] o_meter_full
);

  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
  localparam logic [15:0] UL_MAX = 16'(2 * RATED_CUR);

  logic [31:0] regs [`DSO_NUM_RW];
  logic [31:0] rst_val [`DSO_NUM_RW];
  logic [31:0] wr_merged;
  logic [31:0] wr_val;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic acc_done;
  logic run_seen_rst;
  logic [11:0] flags;
  logic [11:0] base_flags;
  logic [5:0] codes [4];
  logic [3:0] hits;
  logic fault_latched_flag;
  logic pid_second_stage_out;
  logic run_q;
  logic [14:0] tick_cnt;
  logic tick;
  logic [15:0] wdog_cnt;
  logic [15:0] opt_cnt;
  logic watchdog_timeout_flag;
  logic option_link_fault;
  logic underload_flag;
  logic gate_out;
  logic next_out11;
  logic next_relay;

  // ****************************************
  // Avalon-MM register access
  // ****************************************
  // Byte lane merge of write data
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Access completes on the edge where waitrequest is seen low
  assign acc_done = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
  assign wr_merged = (i_avs_address < 4'(`DSO_NUM_RW)) ?
                     be_merge(regs[i_avs_address], i_avs_writedata, i_avs_byteenable) : `DSO_ZERO_RST;
  // Underload level is kept within twice rated current
  assign wr_val = (i_avs_address == `DSO_REG_UL_LEVEL && wr_merged[`DSO_LVL] > UL_MAX) ?
                  {16'h0000, UL_MAX} : wr_merged;

  // Reset values; relay inverted, terminal code 01, relay code 05
  assign rst_val[0] = `DSO_CFG_RST;
  assign rst_val[1] = {16'h0000, RATED_CUR};
  assign rst_val[2] = {16'h0000, RATED_CUR};
  assign rst_val[3] = `DSO_PID_DEV_RST;
  assign rst_val[4] = `DSO_PID_LIM_RST;
  assign rst_val[5] = `DSO_ZERO_RST;
  assign rst_val[6] = `DSO_ZERO_RST;
  assign rst_val[7] = `DSO_ZERO_RST;
  assign rst_val[8] = `DSO_ZERO_RST;

  // One storage register per index
  for (genvar r = 0; r < `DSO_NUM_RW; r++) begin : g_reg
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        regs[r] <= (r == 0) ? `DSO_CFG_RST : (r == 3) ? `DSO_PID_DEV_RST :
                   (r == 4) ? `DSO_PID_LIM_RST : `DSO_ZERO_RST;
      end else if (!run_seen_rst && (r == 1 || r == 2)) begin
        regs[r] <= rst_val[r];
      end else if (acc_done && i_avs_write && i_avs_address == 4'(r)) begin
        regs[r] <= wr_val;
      end
    end
  end

  // Load parameter-valued reset levels once after release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_seen_rst <= 1'b0;
    end else begin
      run_seen_rst <= 1'b1;
    end
  end

  // Status word shows live flags and pin levels
  assign status = {14'h0000, o_relay, o_out11, 4'h0, flags};
  assign rd_mux = (i_avs_address < 4'(`DSO_NUM_RW)) ? regs[i_avs_address] :
                  (i_avs_address == `DSO_REG_STATUS) ? status : `DSO_ZERO_RST;

  // Waitrequest drops for one cycle per request
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= `DSO_ZERO_RST;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
      o_avs_readdata <= rd_mux;
    end
  end

  // ****************************************
  // Status flag conditions
  // ****************************************
  // Flags in dso_func_t order: drive state compares, fault latch, timers, gate and detectors
  assign flags[0] = i_running;
  assign flags[1] = i_running & ~i_ramping & (i_out_freq == i_target_freq);
  assign flags[2] = i_running & (i_out_freq >= i_target_freq);
  assign flags[3] = i_out_current > regs[`DSO_REG_OL_LEVEL][`DSO_LVL];
  assign flags[4] = i_pid_err_mag > regs[`DSO_REG_PID_DEV][`DSO_LVL];
  assign flags[5] = fault_latched_flag;
  assign flags[6] = (i_volt_ain < regs[`DSO_REG_LOSS][`DSO_LVL]) | (i_cur_ain < `DSO_AIN_4MA);
  assign flags[7] = pid_second_stage_out;
  assign flags[8] = watchdog_timeout_flag;
  assign flags[9] = gate_out;
  assign flags[10] = option_link_fault;
  assign flags[11] = underload_flag;

  // Fault latch; a new fault wins over a clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_latched_flag <= 1'b0;
    end else if (i_fault_event) begin
      fault_latched_flag <= 1'b1;
    end else if (i_fault_clear) begin
      fault_latched_flag <= 1'b0;
    end
  end

  // PID second stage hysteresis, dropped on run to stop
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      pid_second_stage_out <= 1'b0;
    end else begin
      run_q <= i_running;
      if ((run_q & ~i_running) ||
          i_pid_feedback > regs[`DSO_REG_PID_LIM][`DSO_LIM_UPPER]) begin
        pid_second_stage_out <= 1'b0;
      end else if (i_running && i_pid_feedback < regs[`DSO_REG_PID_LIM][`DSO_LIM_LOWER]) begin
        pid_second_stage_out <= 1'b1;
      end
    end
  end

  // ****************************************
  // Timeout timers
  // ****************************************
  // Millisecond tick shared by both timers
  assign tick = (tick_cnt == TICK_LAST);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= 15'h0000;
    end else begin
      tick_cnt <= tick ? 15'h0000 : tick_cnt + 15'h0001;
    end
  end

  // Activity restarts each count; counts saturate
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdog_cnt <= 16'h0000;
      opt_cnt <= 16'h0000;
    end else begin
      if (i_comm_activity) begin
        wdog_cnt <= 16'h0000;
      end else if (tick && wdog_cnt != `DSO_CNT_MAX) begin
        wdog_cnt <= wdog_cnt + 16'h0001;
      end
      if (i_option_activity) begin
        opt_cnt <= 16'h0000;
      end else if (tick && opt_cnt != `DSO_CNT_MAX) begin
        opt_cnt <= opt_cnt + 16'h0001;
      end
    end
  end

  // A zero period disables the timeout
  assign watchdog_timeout_flag = (regs[`DSO_REG_WDOG][`DSO_LVL] != 16'h0000) &
                                 (wdog_cnt >= regs[`DSO_REG_WDOG][`DSO_LVL]);
  assign option_link_fault = (regs[`DSO_REG_OPT_TO][`DSO_LVL] != 16'h0000) &
                             (opt_cnt >= regs[`DSO_REG_OPT_TO][`DSO_LVL]);

  // ****************************************
  // Underload warning
  // ****************************************
  // Flag feeds the selectors and the status word, nothing trips
  dso_underload u_underload (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_mode(regs[`DSO_REG_CFG][`DSO_CFG_ULMODE]),
    .i_level(regs[`DSO_REG_UL_LEVEL][`DSO_LVL]),
    .i_current(i_out_current),
    .i_running(i_running),
    .i_ramping(i_ramping),
    .o_flag(underload_flag)
  );

  // ****************************************
  // Function selectors
  // ****************************************
  // Channels 0,1 gate operands; 2 terminal; 3 relay
  assign codes[0] = regs[`DSO_REG_GATE][`DSO_GATE_A];
  assign codes[1] = regs[`DSO_REG_GATE][`DSO_GATE_B];
  assign codes[2] = regs[`DSO_REG_CFG][`DSO_CFG_F11];
  assign codes[3] = regs[`DSO_REG_CFG][`DSO_CFG_FRY];
  assign base_flags = {flags[11:10], 1'b0, flags[8:0]};

  for (genvar c = 0; c < 4; c++) begin : g_sel
    dso_func_mux u_mux (
      .i_code(codes[c]),
      .i_flags((c < 2) ? base_flags : flags),
      .o_hit(hits[c])
    );
  end

  // Gate combines the two operand results
  assign gate_out = (dso_gate_op_t'(regs[`DSO_REG_GATE][`DSO_GATE_OP]) == DSO_G_AND) ? (hits[0] & hits[1]) :
                    (dso_gate_op_t'(regs[`DSO_REG_GATE][`DSO_GATE_OP]) == DSO_G_OR) ? (hits[0] | hits[1]) :
                    (dso_gate_op_t'(regs[`DSO_REG_GATE][`DSO_GATE_OP]) == DSO_G_XOR) ? (hits[0] ^ hits[1]) :
                    1'b0;

  // Polarity bit inverts the pin sense
  assign next_out11 = hits[2] ^ regs[`DSO_REG_CFG][`DSO_CFG_P11];
  assign next_relay = hits[3] ^ regs[`DSO_REG_CFG][`DSO_CFG_PRY];

  // ****************************************
  // Registered outputs
  // ****************************************
  // Pins and meter update every cycle, low in reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out11 <= 1'b0;
      o_relay <= 1'b0;
      o_meter_value <= 16'h0000;
      o_meter_full <= 16'h0000;
    end else begin
      o_out11 <= next_out11;
      o_relay <= next_relay;
      o_meter_value <= regs[`DSO_REG_CFG][`DSO_CFG_METER] ? i_out_current : i_out_freq;
      o_meter_full <= regs[`DSO_REG_CFG][`DSO_CFG_METER] ? UL_MAX : MAX_FREQ;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/dso_underload.sv
// Purpose: Underload detector raising a warning flag only
// Assumes: Current and level share one unit
// Notes: Flag is registered
`timescale 1ns/1ns
`default_nettype none
module dso_underload
  import dso_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Settings and drive state
  input wire logic [1:0] i_mode,
  input wire logic [15:0] i_level,
  input wire logic [15:0] i_current,
  input wire logic i_running,
  input wire logic i_ramping,
  // Warning flag
  output logic o_flag
);

  logic window;
  logic next_flag;

  // ****************************************
  // Detection window and compare
  // ****************************************
  // Mode decides in which phases detection is live
  assign window = (dso_ul_mode_t'(i_mode) == DSO_UL_ALL) ? i_running :
                  (dso_ul_mode_t'(i_mode) == DSO_UL_CONST) ? (i_running & ~i_ramping) :
                  1'b0;
  assign next_flag = window & (i_current < i_level);

  // Register the flag
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule
`default_nettype wire
